// >>> include/mar_pkg.sv
// Purpose: Shared constants and types of the four-channel readout block.
// Assumes: A 10 MHz core clock and a 32-bit APB register bus.
// Notes:   Register offsets are byte addresses, one aligned word per register.
package mar_pkg;

   // ==========================================================================
   // Geometry and timing
   // ==========================================================================
   localparam int NCH                 = 4;            // Converter channels.
   localparam int DW                  = 24;           // Sample width.
   localparam int SUM_W               = 28;           // Running sum of 16 samples.
   localparam int HIST_D              = 16;           // Largest averaging count.
   localparam int CORE_CLK_PERIOD_NS  = 100;          // Core clock period in ns.
   localparam int CORE_CLK_HZ         = 1_000_000_000 / CORE_CLK_PERIOD_NS;
   localparam int FIFO_DEPTH_DEF      = 16;           // Stream buffer depth.

   // Conversion rates in samples per second, indexed by the rate field.
   localparam int unsigned RATE_SPS [8] = '{20, 40, 80, 160, 320, 500, 1000, 2000};

   // ==========================================================================
   // Register map
   // ==========================================================================
   localparam logic [7:0]  OFS_CTRL   = 8'h00;        // Run, stream, rate, average.
   localparam logic [7:0]  OFS_MODE   = 8'h04;        // Three bits per channel.
   localparam logic [7:0]  OFS_STAT   = 8'h08;        // Live state, read only.
   localparam logic [7:0]  OFS_CJC    = 8'h0C;        // Cold-junction reading.
   localparam logic [7:0]  OFS_DATA0  = 8'h10;        // Latest value, channel 0.
   localparam logic [7:0]  OFS_STEP   = 8'h04;        // Stride of the data ports.
   localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
   localparam logic [11:0] MODE_RST   = 12'h000;
   localparam int          MODE_W     = 3;
   localparam logic [2:0]  AVG_MAX    = 3'h4;         // Select 4 means 16 samples.
   localparam int          STAT_LVL_LSB = 8;
   localparam int          STAT_CNT_LSB = 16;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef enum logic [2:0] {
      MAR_VOLT, MAR_CURR, MAR_FBRIDGE, MAR_HBRIDGE, MAR_TC, MAR_RTD, MAR_WRES
   } mar_mode_t;

   // Control word, laid out as bits 7..0 of the control register.
   typedef struct packed {
      logic [2:0] avg;    // 0 bypass, k gives 2**k samples.
      logic [2:0] rate;   // Index into RATE_SPS.
      logic       strm;   // Continuous block delivery.
      logic       run;    // Conversions running.
   } mar_ctrl_t;

   // One stream word: channel number and its result.
   typedef struct packed {
      logic [1:0]    ch;
      logic [DW-1:0] data;
   } mar_smp_t;

endpackage : mar_pkg

// >>> src/mar_fifo.sv
// Purpose: Stream buffer between the sample engine and the host link.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Depth must be a power of two; head word is read from registers.
`timescale 1ns/10ps

module mar_fifo #(
   parameter int W     = 26,
   parameter int DEPTH = 16
) (
   input  wire logic                       CLK,
   input  wire logic                       RST,
   input  wire logic                       IN_VALID,
   output      logic                       IN_READY,
   input  wire logic [W-1:0]               IN_DATA,
   output      logic                       OUT_VALID,
   input  wire logic                       OUT_READY,
   output      logic [W-1:0]               OUT_DATA,
   output      logic [$clog2(DEPTH+1)-1:0] LEVEL
);

   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);   // Width of the word count.

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("mar_fifo depth must be a power of two of at least 2.");
   end

   logic [W-1:0]              mem_r [DEPTH];  // Storage words.
   logic [AW-1:0]             wptr_r;         // Next slot to fill.
   logic [AW-1:0]             rptr_r;         // Oldest word.
   logic [$clog2(DEPTH+1)-1:0] cnt_r;         // Words held.
   logic                      push;           // Word accepted.
   logic                      pop;            // Word delivered.

   // Full and empty come straight from the word count.
   assign IN_READY  = (cnt_r != CW'(DEPTH));
   assign OUT_VALID = (cnt_r != '0);
   assign push      = IN_VALID && IN_READY;
   assign pop       = OUT_VALID && OUT_READY;
   assign OUT_DATA  = mem_r[rptr_r];
   assign LEVEL     = cnt_r;

   // Storage is written only on an accepted word.
   always_ff @(posedge CLK) begin
      if (push) begin
         mem_r[wptr_r] <= IN_DATA;
      end
   end

   // Pointers and count move on accepted words at each end.
   always_ff @(posedge CLK) begin
      if (RST) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r  <= '0;
      end else begin
         if (push) begin
            wptr_r <= wptr_r + 1'b1;
         end
         if (pop) begin
            rptr_r <= rptr_r + 1'b1;
         end
         if (push && !pop) begin
            cnt_r <= cnt_r + 1'b1;
         end else if (pop && !push) begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

endmodule : mar_fifo

// >>> src/mar_readout.sv
// Purpose: Readout engine of a four-channel 24-bit acquisition front end.
// Assumes: Converter results arrive together with a one-cycle done strobe.
// Notes:   Registers over APB; continuous data leave through a buffered stream.
//
// How it works
// [R01] Each channel holds its own input mode.
// [R02] Averaging count 0, 2, 4, 8, 16; zero bypasses.
// [R03] Results are 24-bit two's complement values.
// [R04] Codes span 800000 through 7FFFFF, zero 000000.
// [R05] Eight rates, chosen while acquisition is stopped.
// [R06] Poll port overwritten by every new result.
// [R07] Repeated poll reads return the stored value.
// [R08] Stream delivers every sample, none lost, none doubled.
// [R09] Host buffer is a multiple of 128 samples.
// [R10] Cold-junction temperature readable in degrees Celsius.
// [R11] All channels convert together at one rate.
// [R12] Filter output is mean of latest N.
//
// Added by the designer: the APB slave port and the address map.
`timescale 1ns/10ps

module mar_readout
   import mar_pkg::*;
#(
   parameter int CLK_HZ     = CORE_CLK_HZ,     // Shorten for simulation.
   parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
   input  wire logic                  CORE_CLK,
   input  wire logic                  RST,
   input  wire logic                  PSEL,
   input  wire logic                  PENABLE,
   input  wire logic                  PWRITE,
   input  wire logic [7:0]            PADDR,
   input  wire logic [31:0]           PWDATA,
   output      logic [31:0]           PRDATA,
   output      logic                  PREADY,
   output      logic                  PSLVERR,
   output      logic                  CONV_START,
   input  wire logic                  CONV_DONE,
   input  wire logic [NCH-1:0][DW-1:0] RAW_DATA,
   input  wire logic [15:0]           CJ_TEMP,
   output      logic [NCH-1:0][2:0]   MODE_SEL,
   output      logic                  STRM_VALID,
   input  wire logic                  STRM_READY,
   output      logic [DW+1:0]         STRM_DATA
);

   // ==========================================================================
   // Elaboration checks
   // ==========================================================================
   if (CLK_HZ / 2000 < 2) begin : g_bad_clk
      $error("mar_readout clock too slow for the fastest rate.");
   end

   typedef enum logic {S_IDLE, S_PROC} mar_state_t;

   localparam int LVW = $clog2(FIFO_DEPTH + 1);

   mar_ctrl_t                 ctrl_r;              // Control register.
   logic [NCH-1:0][2:0]       mode_r;              // Per-channel modes.
   logic [DW-1:0]             raw_r  [NCH];        // Captured conversion set.
   logic [DW-1:0]             poll_r [NCH];        // Latest-value ports.
   logic [DW-1:0]             hist_r [NCH][HIST_D]; // Raw history rings.
   logic signed [SUM_W-1:0]   sum_r  [NCH];        // Running window sums.
   logic [3:0]                wptr_r;              // Ring slot of this set.
   logic [1:0]                ch_r;                // Channel being processed.
   mar_state_t                st_r;                // Engine state.
   logic [31:0]               div_cnt_r;           // Conversion interval count.
   logic [15:0]               conv_cnt_r;          // Completed sets.
   logic [31:0]               prdata_r;            // Registered read data.
   logic                      wr_en;               // APB write takes effect.
   logic                      rd_setup;            // APB read setup cycle.
   logic                      addr_ok;             // Address is mapped.
   logic [31:0]               rd_nxt;              // Read mux result.
   logic [31:0]               div_lim;             // Cycles per conversion.
   logic                      tick;                // Interval elapsed.
   logic                      advance;             // Channel step completes.
   logic                      flt_clr;             // Averaging count changed.
   logic [DW-1:0]             cur_raw;             // Raw value of ch_r.
   logic [4:0]                n_cnt;               // Window length.
   logic [3:0]                old_idx;             // Slot leaving the window.
   logic signed [SUM_W-1:0]   sum_nxt;             // Updated window sum.
   logic signed [SUM_W-1:0]   mean_full;           // Sum divided by N.
   logic [DW-1:0]             filt;                // Result for ch_r.
   logic                      fifo_in_ready;       // Buffer has room.
   logic [LVW-1:0]            fifo_lvl;            // Buffer occupancy.
   mar_smp_t                  smp;                 // Word offered to the buffer.
   mar_ctrl_t                 ctrl_wr;             // Control word being written.
   logic [NCH-1:0][2:0]       mode_wr;             // Mode word being written.

   // Sign extension of a result into the running-sum width.
   function automatic logic signed [SUM_W-1:0] sx(input logic [DW-1:0] v);
      sx = {{(SUM_W - DW){v[DW-1]}}, v};
   endfunction : sx

   // ==========================================================================
   // APB slave
   // ==========================================================================
   // Zero wait states: read data are captured in the setup cycle.
   assign wr_en    = PSEL && PENABLE && PWRITE;
   assign rd_setup = PSEL && !PENABLE && !PWRITE;
   assign addr_ok  = (PADDR[1:0] == 2'h0) && (PADDR <= OFS_DATA0 + 8'(3 * OFS_STEP));
   assign PREADY   = 1'b1;
   assign PSLVERR  = PSEL && PENABLE && !addr_ok;
   assign PRDATA   = prdata_r;
   assign ctrl_wr  = PWDATA[7:0];
   assign mode_wr  = PWDATA[11:0];

   // Read multiplexer; data ports hold 24 bits with zeros above.
   always_comb begin
      rd_nxt = 32'h0000_0000;
      case (PADDR)
         OFS_CTRL: rd_nxt = {24'h00_0000, ctrl_r};
         OFS_MODE: rd_nxt = {20'h0_0000, mode_r};
         OFS_STAT: begin
            rd_nxt[STAT_CNT_LSB +: 16] = conv_cnt_r;
            rd_nxt[STAT_LVL_LSB +: LVW] = fifo_lvl;
            rd_nxt[0] = ctrl_r.run;
            rd_nxt[1] = (st_r == S_PROC);
         end
         OFS_CJC:  rd_nxt = {{16{CJ_TEMP[15]}}, CJ_TEMP}; // R10
         default: begin
            if (addr_ok && PADDR >= OFS_DATA0) begin
               rd_nxt = {8'h00, poll_r[2'(PADDR[3:2])]}; // R07
            end
         end
      endcase
   end

   // Read data register, loaded only on a read setup.
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         prdata_r <= 32'h0000_0000;
      end else if (rd_setup) begin
         prdata_r <= rd_nxt;
      end
   end

   // Control register; rate and averaging are locked while running.
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_r <= CTRL_RST[7:0];
      end else if (wr_en && PADDR == OFS_CTRL) begin
         ctrl_r.run  <= ctrl_wr.run;
         ctrl_r.strm <= ctrl_wr.strm;
         if (!ctrl_r.run) begin
            ctrl_r.rate <= ctrl_wr.rate; // R05
            if (ctrl_wr.avg <= AVG_MAX) begin
               ctrl_r.avg <= ctrl_wr.avg; // R02
            end
         end
      end
   end

   // Averaging history restarts whenever the window length changes.
   assign flt_clr = wr_en && PADDR == OFS_CTRL && !ctrl_r.run &&
                    ctrl_wr.avg <= AVG_MAX && ctrl_wr.avg != ctrl_r.avg;

   // Mode fields are taken one by one; an unused code keeps the old mode.
   for (genvar i = 0; i < NCH; i++) begin : g_mode
      always_ff @(posedge CORE_CLK) begin
         if (RST) begin
            mode_r[i] <= MODE_RST[i*MODE_W +: MODE_W];
         end else if (wr_en && PADDR == OFS_MODE && mode_wr[i] <= MAR_WRES) begin
            mode_r[i] <= mode_wr[i]; // R01
         end
      end
   end
   assign MODE_SEL = mode_r;

   // ==========================================================================
   // Conversion timing
   // ==========================================================================
   assign div_lim = 32'(CLK_HZ) / RATE_SPS[ctrl_r.rate];
   assign tick    = ctrl_r.run && (div_cnt_r >= div_lim - 32'h1);

   // One start for all channels per interval; waits while a set is pending.
   always_ff @(posedge CORE_CLK) begin
      if (RST || !ctrl_r.run) begin
         div_cnt_r  <= 32'h0000_0000;
         CONV_START <= 1'b0;
      end else if (tick && st_r == S_IDLE) begin
         div_cnt_r  <= 32'h0000_0000;
         CONV_START <= 1'b1; // R11
      end else begin
         div_cnt_r  <= tick ? div_cnt_r : div_cnt_r + 32'h1;
         CONV_START <= 1'b0;
      end
   end

   // ==========================================================================
   // Sample engine
   // ==========================================================================
   assign cur_raw   = raw_r[ch_r];
   assign n_cnt     = 5'h01 << ctrl_r.avg;
   assign old_idx   = wptr_r - n_cnt[3:0];
   assign sum_nxt   = sum_r[ch_r] + sx(cur_raw) - sx(hist_r[ch_r][old_idx]); // R12
   assign mean_full = sum_nxt >>> ctrl_r.avg;
   assign filt      = (ctrl_r.avg == 3'h0) ? cur_raw : mean_full[DW-1:0]; // R02
   assign advance   = (st_r == S_PROC) && (!ctrl_r.strm || fifo_in_ready); // R08

   // State and channel walk: capture all four, then one channel per step.
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         st_r       <= S_IDLE;
         ch_r       <= 2'h0;
         conv_cnt_r <= 16'h0000;
      end else begin
         case (st_r)
            S_IDLE: begin
               if (CONV_DONE) begin
                  st_r <= S_PROC; // R11
                  ch_r <= 2'h0;
               end
            end
            S_PROC: begin
               if (advance) begin
                  ch_r <= ch_r + 2'h1;
                  if (ch_r == 2'(NCH - 1)) begin
                     st_r       <= S_IDLE;
                     conv_cnt_r <= conv_cnt_r + 16'h0001;
                  end
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // Raw capture: all channels of one conversion are taken in the same edge.
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < NCH; i++) begin
            raw_r[i] <= '0;
         end
      end else if (st_r == S_IDLE && CONV_DONE) begin
         for (int i = 0; i < NCH; i++) begin
            raw_r[i] <= RAW_DATA[i]; // R03
         end
      end
   end

   // Poll ports: each result overwrites the last, read or not.
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         for (int i = 0; i < NCH; i++) begin
            poll_r[i] <= '0;
         end
      end else if (advance) begin
         poll_r[ch_r] <= filt; // R06
      end
   end

   // History rings and window sums; cleared when the window changes.
   always_ff @(posedge CORE_CLK) begin
      if (RST || flt_clr) begin
         wptr_r <= 4'h0;
         for (int i = 0; i < NCH; i++) begin
            sum_r[i] <= '0;
            for (int j = 0; j < HIST_D; j++) begin
               hist_r[i][j] <= '0;
            end
         end
      end else if (advance) begin
         hist_r[ch_r][wptr_r] <= cur_raw; // R12
         sum_r[ch_r]          <= sum_nxt;
         if (ch_r == 2'(NCH - 1)) begin
            wptr_r <= wptr_r + 4'h1;
         end
      end
   end

   // ==========================================================================
   // Stream buffer
   // ==========================================================================
   assign smp.ch   = ch_r;
   assign smp.data = filt;

   mar_fifo #(
      .W     (DW + 2),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .CLK       (CORE_CLK),
      .RST       (RST),
      .IN_VALID  (st_r == S_PROC && ctrl_r.strm),
      .IN_READY  (fifo_in_ready),
      .IN_DATA   (smp),
      .OUT_VALID (STRM_VALID),
      .OUT_READY (STRM_READY),
      .OUT_DATA  (STRM_DATA),
      .LEVEL     (fifo_lvl)
   );

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (RST);

   AST_MODE_TAKE: assert property ( // R01
      (wr_en && PADDR == OFS_MODE && PWDATA[2:0] <= 3'h6) |=> MODE_SEL[0] == $past(PWDATA[2:0])
   ) else $error("Channel 0 mode not taken from write.");

   AST_BYPASS: assert property ( // R02
      (advance && ctrl_r.avg == 3'h0) |=> poll_r[$past(ch_r)] == $past(cur_raw)
   ) else $error("Bypassed filter altered the result.");

   AST_DATA_HIGH_ZERO: assert property ( // R04
      (rd_setup && PADDR >= OFS_DATA0 && addr_ok) |=> PRDATA[31:24] == 8'h00
   ) else $error("Data port upper bits not zero.");

   AST_POLL_HOLD: assert property ( // R07
      (st_r == S_IDLE && $past(st_r) == S_IDLE) |-> $stable(poll_r[0]) && $stable(poll_r[3])
   ) else $error("Poll port changed without a new conversion.");

   AST_NO_LOSS: assert property ( // R08
      (st_r == S_PROC && ctrl_r.strm && !fifo_in_ready) |=> st_r == S_PROC && $stable(ch_r)
   ) else $error("Sample step advanced while buffer full.");

   AST_RATE_LOCK: assert property ( // R05
      (ctrl_r.run && wr_en && PADDR == OFS_CTRL) |=> ctrl_r.rate == $past(ctrl_r.rate)
   ) else $error("Rate changed during acquisition.");

   AST_CAPTURE: assert property ( // R11
      (st_r == S_IDLE && CONV_DONE) |=> st_r == S_PROC && ch_r == 2'h0 &&
         raw_r[3] == $past(RAW_DATA[3]) && raw_r[0] == $past(RAW_DATA[0])
   ) else $error("Conversion set not captured together.");

   AST_SET_LEN: assert property ( // R06
      (st_r == S_IDLE && CONV_DONE && !ctrl_r.strm) |=> st_r == S_PROC [*4] ##1 st_r == S_IDLE
   ) else $error("Set did not take four steps.");

   AST_START_GAP: assert property ( // R05
      CONV_START |=> !CONV_START
   ) else $error("Conversion start wider than one cycle.");

   AST_CJC: assert property ( // R10
      (rd_setup && PADDR == OFS_CJC) |=> PRDATA[15:0] == $past(CJ_TEMP)
   ) else $error("Cold-junction reading mismatch.");

   COV_STREAM_FULL: cover property (st_r == S_PROC && ctrl_r.strm && !fifo_in_ready);
   COV_AVG16:       cover property (advance && ctrl_r.avg == AVG_MAX);
   COV_POLL_READ:   cover property (rd_setup && PADDR == OFS_DATA0);

endmodule : mar_readout

// >>> tb/mar_host.sv
// Purpose: Host side of the sample stream, taking words from the readout block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   STALL holds ready low; SLOW takes at most one word in four cycles.
`timescale 1ns/10ps

module mar_host (
   input  wire logic CLK,
   input  wire logic RST,
   input  wire logic STALL,
   input  wire logic SLOW,
   input  wire logic STRM_VALID,
   output      logic STRM_READY,
   output      int   N_WORDS
);
   // ==========================================================================
   // Ready pattern and word count
   // ==========================================================================
   logic [1:0] ph_r;          // Phase of the slow acceptance pattern.

   // Ready only changes just after an edge, so a word moves cleanly or not at all.
   always_ff @(posedge CLK) begin
      if (RST) begin
         ph_r <= 2'h0;
         N_WORDS <= 0;
         STRM_READY <= 1'b0;
      end else begin
         ph_r <= ph_r + 2'h1;
         STRM_READY <= !STALL && (!SLOW || ph_r == 2'h3);
         if (STRM_VALID && STRM_READY) begin
            N_WORDS <= N_WORDS + 1;
         end
      end
   end

endmodule : mar_host

// >>> tb/testbench.sv
// Purpose: Self-checking bench of the readout engine against a queue model.
// Assumes: CLK_HZ shortened to 4000, so the slowest rate is 200 cycles a set.
// Notes:   The model predicts every poll port value and every stream word.
`timescale 1ns/10ps

module testbench;
   import mar_pkg::*;
   // ==========================================================================
   // Signals and model state
   // ==========================================================================
   localparam int HZ = 4000;                 // Shortened core rate.
   localparam int HOST_BUF = 128;            // Host buffer, whole blocks of samples.
   logic CORE_CLK, RST, psel, penable, pwrite, conv_done, stall, slow, err;
   logic PREADY, PSLVERR, CONV_START, STRM_VALID, STRM_READY;
   logic [7:0]             paddr;            // APB address.
   logic [31:0]            pwdata, PRDATA, rd, v;
   logic [NCH-1:0][DW-1:0] raw;              // Converter results.
   logic [15:0]            cj;               // Cold-junction reading.
   logic [NCH-1:0][2:0]    MODE_SEL;
   logic [DW+1:0]          STRM_DATA;
   logic [23:0]            poll[4];          // Expected poll ports.
   logic [23:0] bnd[4] = '{24'h7FFFFF, 24'h800000, 24'hFFFFFF, 24'h000000};
   logic [11:0] mt[3] = '{12'hD63, 12'hD67, 12'h088}; // Mode 7 on ch0 is refused.
   logic [11:0] me[3] = '{12'hD63, 12'hD63, 12'h088};
   mar_smp_t expq[$];                        // Expected stream words.
   int hist[4][16];
   int n_mismatch, cmp_count, cyc, n_set, avg, s, f, gap, n_words, seed, n_push;
   bit strm;

   mar_readout #(.CLK_HZ(HZ)) mar_readout_inst (.CORE_CLK(CORE_CLK), .RST(RST), .PSEL(psel),
      .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(PRDATA),
      .PREADY(PREADY), .PSLVERR(PSLVERR), .CONV_START(CONV_START), .CONV_DONE(conv_done),
      .RAW_DATA(raw), .CJ_TEMP(cj), .MODE_SEL(MODE_SEL), .STRM_VALID(STRM_VALID),
      .STRM_READY(STRM_READY), .STRM_DATA(STRM_DATA));
   mar_host mar_host_inst (.CLK(CORE_CLK), .RST(RST), .STALL(stall), .SLOW(slow),
      .STRM_VALID(STRM_VALID), .STRM_READY(STRM_READY), .N_WORDS(n_words));

   initial begin
      CORE_CLK = 1'b0;
      forever #50 CORE_CLK = ~CORE_CLK;
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge CORE_CLK);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge CORE_CLK);
      penable <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      err = PSLVERR;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic ctl(input int r, input bit run);
      apb(1'b1, OFS_CTRL, {24'h0, 3'(avg), 3'(r), strm, run});
   endtask : ctl

   task automatic ws();
      do @(posedge CORE_CLK); while (CONV_START !== 1'b1);
   endtask : ws

   // Each port is read twice; between conversions both reads must agree.
   task automatic rdp();
      for (int c = 0; c < NCH; c++) begin
         repeat (2) begin
            apb(1'b0, 8'(OFS_DATA0 + OFS_STEP * c), 32'h0);
            chk(rd, {8'h00, poll[c]});
         end
      end
   endtask : rdp

   task automatic conclude();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   // ==========================================================================
   // Converter, model and stream monitor
   // ==========================================================================
   // Answers every start with one set; the model filters it like the block should.
   always @(posedge CORE_CLK) begin
      conv_done <= 1'b0;
      if (CONV_START === 1'b1) begin
         for (int c = 0; c < NCH; c++) begin
            v = $random(seed);
            if (n_set == 0) v[23:0] = bnd[c];
            raw[c] <= v[DW-1:0];
            for (int k = 15; k > 0; k--) hist[c][k] = hist[c][k-1];
            hist[c][0] = {{8{v[23]}}, v[23:0]};
            s = 0;
            for (int k = 0; k < (1 << avg); k++) s += hist[c][k];
            f = s >>> avg;
            poll[c] = f[23:0];
            if (strm) begin
               expq.push_back({c[1:0], f[23:0]});
               n_push++;
            end
         end
         conv_done <= 1'b1;
         n_set++;
      end
   end

   // Every moved word must be the next predicted one; a surplus word fails.
   always @(posedge CORE_CLK) begin
      cyc++;
      if (STRM_VALID === 1'b1 && STRM_READY === 1'b1)
         chk({6'h0, STRM_DATA}, expq.size() ? {6'h0, expq.pop_front()} : 32'hFFFFFFFF);
      if (cyc == 60000) begin
         n_mismatch++;
         conclude();
      end
   end

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      seed = 32'hA6D5;
      {RST, psel, penable, pwrite, paddr, pwdata, stall, slow} = 46'h0;
      RST = 1'b1;
      raw = '0;
      cj = 16'($random(seed));
      repeat (4) @(posedge CORE_CLK);
      RST <= 1'b0;
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, CTRL_RST);
      apb(1'b0, 8'h40, 32'h0);
      chk({rd[30:0], err}, 32'h1);
      apb(1'b0, OFS_CJC, 32'h0);
      chk(rd, {{16{cj[15]}}, cj});
      for (int i = 0; i < 3; i++) begin
         apb(1'b1, OFS_MODE, {20'h0, mt[i]});
         apb(1'b0, OFS_MODE, 32'h0);
         chk(rd, {20'h0, me[i]});
         chk({20'h0, MODE_SEL}, {20'h0, me[i]});
      end
      for (int j = 1; j < 3; j++) begin
         ctl(0, 1'b1);
         repeat (j) ws();
         ctl(0, 1'b0);
         repeat (20) @(posedge CORE_CLK);
         rdp();
      end
      for (int i = 0; i < 6; i++) begin
         ctl(i, 1'b0);
         ctl(i, 1'b1);
         repeat (2) ws();
         gap = 0;
         do begin
            @(posedge CORE_CLK);
            gap++;
         end while (CONV_START !== 1'b1);
         chk(gap, HZ / RATE_SPS[i]);
         ctl(i, 1'b0);
         repeat (20) @(posedge CORE_CLK);
      end
      avg = 2;
      hist = '{default: 0};
      ctl(5, 1'b0);
      ctl(5, 1'b1);
      repeat (60) @(posedge CORE_CLK);
      apb(1'b1, OFS_CTRL, {24'h0, 3'd3, 3'd4, 1'b0, 1'b1});
      apb(1'b0, OFS_CTRL, 32'h0);
      chk(rd, {24'h0, 3'd2, 3'd5, 1'b0, 1'b1});
      repeat (60) @(posedge CORE_CLK);
      ctl(5, 1'b0);
      repeat (20) @(posedge CORE_CLK);
      rdp();
      strm = 1'b1;
      stall <= 1'b1;
      ctl(3, 1'b0);
      ctl(3, 1'b1);
      repeat (400) @(posedge CORE_CLK);
      apb(1'b0, OFS_STAT, 32'h0);
      chk({27'h0, rd[12:8]}, 32'd16);
      stall <= 1'b0;
      slow <= 1'b1;
      do @(posedge CORE_CLK); while (n_words < HOST_BUF);
      ctl(3, 1'b0);
      slow <= 1'b0;
      repeat (200) @(posedge CORE_CLK);
      chk(expq.size(), 32'd0);
      chk(n_words, n_push);
      conclude();
   end

endmodule : testbench
